// [szu_pkg.sv]
// Shared constants, types and register map of the serial port
package szu_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_BUF = 8'h99;
  localparam logic [7:0] ADDR_RELL = 8'haa;
  localparam logic [7:0] ADDR_RELH = 8'hba;
  localparam logic [7:0] ADDR_RSEL = 8'hd8;
  localparam logic [7:0] ADDR_PWR = 8'hf0;
  localparam logic [7:0] ADDR_IST = 8'hf1;
  localparam logic [7:0] ADDR_ICLR = 8'hf2;
  localparam logic [7:0] ADDR_IEN = 8'hf3;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic [7:0] RST_RELL = 8'hd9;
  localparam logic [7:0] RST_RELH = 8'h03;
  localparam logic RST_RSEL = 1'b0;
  localparam logic RST_PWR = 1'b0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_MP = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TI = 1;
  localparam int CTRL_RI = 0;
  localparam int RSEL_BD = 7;
  localparam int PWR_DBL = 7;
  localparam int IRQ_TX = 1;
  localparam int IRQ_RX = 0;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int M0_DIV = 12;
  localparam logic [3:0] M0_LAST = 4'(M0_DIV - 1);
  localparam logic [3:0] M0_HALF = 4'(M0_DIV / 2);
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [1:0] PRE_SLOW = 2'h3;
  localparam logic [1:0] PRE_FAST = 2'h1;
  localparam logic [9:0] REL_TOP = 10'h3ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SZU_SHIFT = 2'b00, SZU_ASYNC8 = 2'b01, SZU_FIXED9 = 2'b10, SZU_VAR9 = 2'b11
  } szu_mode_e;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_STOP = 5'b01000, TX_SHIFT = 5'b10000
  } szu_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } szu_rx_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } szu_req_s;
  typedef struct packed {
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } szu_pin_s;

endpackage : szu_pkg

// [szu_sync.sv]
// Two flip-flop synchroniser for the receive pin
`timescale 1ns/100ps
module szu_sync (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Level in and out
  input logic din,
  output logic dout
);
  logic meta_q;

  // Idle-high line, so both stages reset high
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : szu_sync

// [szu_rate.sv]
// Oversampling tick generator, sixteen ticks per bit
`timescale 1ns/100ps
module szu_rate (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Rate selection
  input logic fixed,
  input logic dbl,
  input logic bd,
  input logic [9:0] reload,
  input logic t1_ovf,
  // Tick out
  output logic tick
);
  import szu_pkg::*;

  logic [1:0] pre_q;
  logic [9:0] rel_q;
  logic t1_q;
  logic pre_tick;

  // R1 core clock prescale
  assign pre_tick = (pre_q == (dbl ? PRE_FAST : PRE_SLOW));

  // Prescaler: divide by four, or by two when doubled
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= 2'h0;
    end else begin
      pre_q <= pre_tick ? 2'h0 : pre_q + 2'h1;
    end
  end

  // R10 reload counter period
  // Starts at the top so the first prescaler tick loads the reload value
  always_ff @(posedge clk) begin
    if (rst) begin
      rel_q <= REL_TOP;
    end else if (pre_tick) begin
      rel_q <= (rel_q == REL_TOP) ? reload : rel_q + 10'h001;
    end
  end

  // R9 halve overflow rate
  always_ff @(posedge clk) begin
    if (rst) begin
      t1_q <= 1'b0;
    end else if (t1_ovf) begin
      t1_q <= ~t1_q;
    end
  end

  // R3 R11 source select
  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else if (fixed) begin
      tick <= pre_tick;
    end else if (bd) begin
      tick <= pre_tick && (rel_q == REL_TOP);
    end else begin
      tick <= t1_ovf && (dbl || t1_q);
    end
  end

  // R3 fixed slow rate
  property p_fixed_slow;
    @(posedge clk) disable iff (rst)
      (fixed && !dbl && tick) |=> (!tick [*3] ##1 tick);
  endproperty
  a_fixed_slow: assert property (p_fixed_slow) else $error("fixed rate tick spacing wrong"); // R3
endmodule : szu_rate

// [szu_uart.sv]
// Serial port with shift-register and asynchronous modes
//
// How it works
// R1: all timing derived from core clock
// R2: mode field picks one of four modes
// R3: fixed nine-bit rate is clock/64 or /32
// R4: bit 5 multiprocessor, bit 4 receive enable
// R5: ninth sent bit is transmit_bit_eight
// R6: ninth received bit goes to received_bit_eight
// R7: transmit done set by hardware, software clears
// R8: receive done set by hardware, software clears
// R9: timer overflow source scaled by doubling flag
// R10: reload generator divides by 64*(1024-reload)
// R11: rate_generator_select picks source, variable modes
// R12: power_control bit 7 doubles the rate
// R13: ten-bit reload from low and high
// R14: buffer write loads data and starts sending
// R15: buffer read returns the receive buffer
// R16: serial lines leave on general-purpose pins
// R17: start low, data LSB first, stop high
// R18: multiprocessor mode needs ninth bit one
// R19: shift mode: data on receive, clock transmit
`timescale 1ns/100ps
module szu_uart (
  // Clock and reset
  input logic CLK_SYS,
  input logic RST,
  // Register port
  input szu_pkg::szu_req_s BUS_REQ,
  output logic [7:0] BUS_RDATA,
  // Rate source
  input logic T1_OVF,
  // Serial pins
  input logic RXD_IN,
  output szu_pkg::szu_pin_s PINS,
  // Interrupt
  output logic IRQ
);
  import szu_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] rell_q;
  logic [7:0] relh_q;
  logic rsel_q;
  logic pwr_q;
  logic [1:0] ien_q;
  logic [1:0] ist_q;
  logic [7:0] rx_buf_q;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  szu_mode_e mode;
  logic nine;
  logic wr_ctrl, wr_buf, wr_iclr;
  logic tick16;
  logic rx_s;
  logic rx_prev_q;
  szu_tx_e tx_st_q;
  logic [3:0] tx_ph_q;
  logic [3:0] tx_cnt_q;
  logic [8:0] tx_sh_q;
  logic txd_q;
  logic [3:0] m0_q;
  logic [3:0] m0_next;
  logic m0_rx_q;
  logic rxo_q, rxoe_q;
  szu_rx_e rx_st_q;
  logic [3:0] rx_ph_q;
  logic [3:0] rx_cnt_q;
  logic [8:0] rx_sh_q;
  logic [3:0] last_bit;
  logic tx_bit_end, m0_end, m0_done, m0_samp, m0_go_rx;
  logic rx_sample, stop_pt, rx_ok, rx_fall;
  logic tx_set, rx_set, rb8_ld;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // R2 mode decode
  assign mode = szu_mode_e'(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]);
  assign nine = ctrl_q[CTRL_MODE_HI];
  assign wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == ADDR_CTRL);
  assign wr_buf = BUS_REQ.wr && (BUS_REQ.addr == ADDR_BUF);
  assign wr_iclr = BUS_REQ.wr && (BUS_REQ.addr == ADDR_ICLR);
  assign last_bit = nine ? 4'h8 : 4'h7;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  szu_sync u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .din(RXD_IN),
    .dout(rx_s)
  );

  // R12 R13 rate inputs
  szu_rate u_rate (
    .clk(CLK_SYS),
    .rst(RST),
    .fixed(mode == SZU_FIXED9),
    .dbl(pwr_q),
    .bd(rsel_q),
    .reload({relh_q[1:0], rell_q}),
    .t1_ovf(T1_OVF),
    .tick(tick16)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // R7 R8 hardware set wins
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_q <= RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= BUS_REQ.wdata;
      end
      if (rb8_ld) begin
        ctrl_q[CTRL_RB8] <= rx_sh_q[8];
      end
      if (tx_set) begin
        ctrl_q[CTRL_TI] <= 1'b1;
      end
      if (rx_set) begin
        ctrl_q[CTRL_RI] <= 1'b1;
      end
    end
  end

  // Rate setting registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rell_q <= RST_RELL;
      relh_q <= RST_RELH;
      rsel_q <= RST_RSEL;
      pwr_q <= RST_PWR;
    end else if (BUS_REQ.wr) begin
      if (BUS_REQ.addr == ADDR_RELL) begin
        rell_q <= BUS_REQ.wdata;
      end
      if (BUS_REQ.addr == ADDR_RELH) begin
        relh_q <= BUS_REQ.wdata;
      end
      // R11 select bit
      if (BUS_REQ.addr == ADDR_RSEL) begin
        rsel_q <= BUS_REQ.wdata[RSEL_BD];
      end
      if (BUS_REQ.addr == ADDR_PWR) begin
        pwr_q <= BUS_REQ.wdata[PWR_DBL];
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ien_q <= 2'h0;
    end else if (BUS_REQ.wr && (BUS_REQ.addr == ADDR_IEN)) begin
      ien_q <= BUS_REQ.wdata[1:0];
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ist_q <= 2'h0;
    end else begin
      ist_q <= (ist_q & ~(wr_iclr ? BUS_REQ.wdata[1:0] : 2'h0))
        | {tx_set, rx_set};
    end
  end

  assign IRQ = |(ist_q & ien_q);

  // R15 read mux
  always_comb begin
    case (BUS_REQ.addr)
      ADDR_CTRL: rd_mux = ctrl_q;
      ADDR_BUF: rd_mux = rx_buf_q;
      ADDR_RELL: rd_mux = rell_q;
      ADDR_RELH: rd_mux = relh_q;
      ADDR_RSEL: rd_mux = {rsel_q, 7'h00};
      ADDR_PWR: rd_mux = {pwr_q, 7'h00};
      ADDR_IST: rd_mux = {6'h00, ist_q};
      ADDR_IEN: rd_mux = {6'h00, ien_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data one cycle after the strobe only
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= BUS_REQ.rd ? rd_mux : 8'h00;
    end
  end

  assign BUS_RDATA = rdata_q;

  // ----------------------------------------------------------------
  // Transmit and shift-mode engine
  // ----------------------------------------------------------------
  assign tx_bit_end = tick16 && (tx_ph_q == OVS_LAST);
  assign m0_end = (m0_q == M0_LAST);
  assign m0_next = m0_end ? 4'h0 : m0_q + 4'h1;
  assign m0_done = (tx_st_q == TX_SHIFT) && m0_end && (tx_cnt_q == 4'h7);
  assign m0_samp = (tx_st_q == TX_SHIFT) && m0_rx_q && (m0_q == M0_HALF);
  assign m0_go_rx = ctrl_q[CTRL_REN] && !ctrl_q[CTRL_RI] && (mode == SZU_SHIFT);
  // R7 done at stop start or after bit 8
  assign tx_set = ((tx_st_q == TX_DATA) && tx_bit_end && (tx_cnt_q == last_bit))
    || (m0_done && !m0_rx_q);

  // Bit phase counts oversampling ticks
  always_ff @(posedge CLK_SYS) begin
    if (RST || (tx_st_q == TX_IDLE)) begin
      tx_ph_q <= 4'h0;
    end else if (tick16) begin
      tx_ph_q <= tx_ph_q + 4'h1;
    end
  end

  // Transmit state machine; writes while busy are ignored
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 9'h000;
      txd_q <= 1'b1;
      m0_q <= 4'h0;
      m0_rx_q <= 1'b0;
      rxo_q <= 1'b1;
      rxoe_q <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_cnt_q <= 4'h0;
          m0_q <= 4'h0;
          // R14 R17 write starts frame
          if (wr_buf && (mode != SZU_SHIFT)) begin
            // R5 ninth bit loaded
            tx_sh_q <= {ctrl_q[CTRL_TB8], BUS_REQ.wdata};
            txd_q <= 1'b0;
            tx_st_q <= TX_START;
          // R19 R4 shift-mode start
          end else if (wr_buf || m0_go_rx) begin
            tx_sh_q <= {1'b0, BUS_REQ.wdata};
            m0_rx_q <= !wr_buf;
            rxo_q <= wr_buf ? BUS_REQ.wdata[0] : 1'b1;
            rxoe_q <= wr_buf;
            txd_q <= 1'b0;
            tx_st_q <= TX_SHIFT;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            txd_q <= tx_sh_q[0];
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          // R17 LSB first then stop
          if (tx_bit_end) begin
            tx_sh_q <= tx_sh_q >> 1;
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == last_bit) begin
              txd_q <= 1'b1;
              tx_st_q <= TX_STOP;
            end else begin
              txd_q <= tx_sh_q[1];
            end
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_st_q <= TX_IDLE;
          end
        end
        TX_SHIFT: begin
          // R2 R19 clock low half, high half
          m0_q <= m0_next;
          txd_q <= (m0_next >= M0_HALF);
          if (m0_end) begin
            tx_sh_q <= tx_sh_q >> 1;
            tx_cnt_q <= tx_cnt_q + 4'h1;
            rxo_q <= m0_rx_q ? 1'b1 : tx_sh_q[1];
            if (tx_cnt_q == 4'h7) begin
              txd_q <= 1'b1;
              rxo_q <= 1'b1;
              rxoe_q <= 1'b0;
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // R16 pins to port mux
  assign PINS.txd = txd_q;
  assign PINS.rxd_out = rxo_q;
  assign PINS.rxd_oe = rxoe_q;

  // ----------------------------------------------------------------
  // Asynchronous receiver
  // ----------------------------------------------------------------
  assign rx_fall = rx_prev_q && !rx_s;
  assign rx_sample = tick16 && (rx_ph_q == OVS_LAST);
  assign stop_pt = (rx_st_q == RX_STOP) && rx_sample;
  // R18 address frame filter
  assign rx_ok = !(nine && ctrl_q[CTRL_MP] && !rx_sh_q[8]);
  // R8 done at mid stop or after bit 8
  assign rx_set = (stop_pt && rx_ok) || (m0_done && m0_rx_q);
  // R6 ninth bit captured
  assign rb8_ld = stop_pt && rx_ok && nine;

  // Previous line level for start edge
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_s;
    end
  end

  // Phase realigned at the middle of the start bit
  always_ff @(posedge CLK_SYS) begin
    if (RST || (rx_st_q == RX_IDLE)) begin
      rx_ph_q <= 4'h0;
    end else if ((rx_st_q == RX_START) && tick16 && (rx_ph_q == OVS_MID)) begin
      rx_ph_q <= 4'h0;
    end else if (tick16) begin
      rx_ph_q <= rx_ph_q + 4'h1;
    end
  end

  // Receive state machine
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
    end else if (!ctrl_q[CTRL_REN]) begin
      // R4 receiver held off
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_cnt_q <= 4'h0;
          if ((mode != SZU_SHIFT) && rx_fall) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          // R17 false start rejected
          if (tick16 && (rx_ph_q == OVS_MID)) begin
            rx_st_q <= rx_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == last_bit) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Shift register fills from the top, LSB first
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_sh_q <= 9'h000;
    end else if (((rx_st_q == RX_DATA) && rx_sample) || m0_samp) begin
      rx_sh_q <= {rx_s, rx_sh_q[8:1]};
    end
  end

  // Receive buffer, separate from transmit data
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_buf_q <= RST_BUF;
    end else if (rx_set) begin
      rx_buf_q <= nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_clk_low;
    !txd_q [*6];
  endsequence
  sequence s_clk_high;
    txd_q [*6];
  endsequence

  property p_m0_clock;
    @(posedge CLK_SYS) disable iff (RST)
      ((tx_st_q == TX_SHIFT) && (m0_q == 4'h0)) |-> s_clk_low ##1 s_clk_high;
  endproperty
  a_m0_clock: assert property (p_m0_clock) else $error("shift clock not 12 cycles"); // R2

  property p_rx_off;
    @(posedge CLK_SYS) disable iff (RST)
      !ctrl_q[CTRL_REN] |=> (rx_st_q == RX_IDLE);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver active while disabled"); // R4

  property p_tb8;
    @(posedge CLK_SYS) disable iff (RST)
      ((tx_st_q == TX_IDLE) && wr_buf && nine) |=> (tx_sh_q[8] == $past(ctrl_q[CTRL_TB8]));
  endproperty
  a_tb8: assert property (p_tb8) else $error("ninth bit not loaded"); // R5

  property p_rb8;
    @(posedge CLK_SYS) disable iff (RST)
      rb8_ld |=> (ctrl_q[CTRL_RB8] == $past(rx_sh_q[8]));
  endproperty
  a_rb8: assert property (p_rb8) else $error("received ninth bit lost"); // R6

  property p_ti_stop;
    @(posedge CLK_SYS) disable iff (RST)
      ((tx_st_q == TX_DATA) && tx_bit_end && (tx_cnt_q == last_bit))
        |=> (ctrl_q[CTRL_TI] && txd_q && (tx_st_q == TX_STOP));
  endproperty
  a_ti_stop: assert property (p_ti_stop) else $error("transmit done not at stop start"); // R7

  property p_ti_hold;
    @(posedge CLK_SYS) disable iff (RST)
      (ctrl_q[CTRL_TI] && !wr_ctrl) |=> ctrl_q[CTRL_TI];
  endproperty
  a_ti_hold: assert property (p_ti_hold) else $error("transmit done cleared by hardware"); // R7

  property p_ri_hold;
    @(posedge CLK_SYS) disable iff (RST)
      (ctrl_q[CTRL_RI] && !wr_ctrl) |=> ctrl_q[CTRL_RI];
  endproperty
  a_ri_hold: assert property (p_ri_hold) else $error("receive done cleared by hardware"); // R8

  property p_tx_go;
    @(posedge CLK_SYS) disable iff (RST)
      ((tx_st_q == TX_IDLE) && wr_buf && (mode != SZU_SHIFT))
        |=> (!txd_q && (tx_st_q == TX_START));
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("write did not start frame"); // R14

  property p_rd_buf;
    @(posedge CLK_SYS) disable iff (RST)
      (BUS_REQ.rd && (BUS_REQ.addr == ADDR_BUF)) |=> (BUS_RDATA == $past(rx_buf_q));
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("buffer read not receive data"); // R15

  property p_mp;
    @(posedge CLK_SYS) disable iff (RST)
      (stop_pt && nine && ctrl_q[CTRL_MP] && !rx_sh_q[8] && !ctrl_q[CTRL_RI]
        && !wr_ctrl && !m0_done) |=> !ctrl_q[CTRL_RI];
  endproperty
  a_mp: assert property (p_mp) else $error("data frame flagged in multiprocessor mode"); // R18

endmodule : szu_uart

// [szu_peer.sv]
// Remote serial peer that talks to the port over its two lines
`timescale 1ns/100ps
module szu_peer (
  // Clock
  input logic clk,
  // Serial lines
  input logic txd,
  output logic rxd
);
  // Line idles high between frames
  initial rxd = 1'b1;

  // ------------------------------------------------------------
  // Frame driver and catcher
  // ------------------------------------------------------------
  // start, LSB first, stop
  task automatic send(input logic [8:0] v, input int n, input int per);
    logic [10:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i + 1] = v[i];
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (per - 1) @(posedge clk);
    end
  endtask : send

  task automatic catch_frame(input int n, input int per, output logic [10:0] v);
    v = '1;
    @(negedge txd);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n + 2; i++) begin
      v[i] = txd;
      if (i < n + 1) repeat (per) @(posedge clk);
    end
  endtask : catch_frame

  // shift-mode data, changed on each shift clock fall
  task automatic shift_in(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      rxd <= v[i];
    end
  endtask : shift_in
endmodule : szu_peer

// [szu_uart_bench.sv]
// Self-checking bench for the serial port
`timescale 1ns/100ps
module szu_uart_bench;
  import szu_pkg::*;
  localparam int BIT = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic t1_ovf = 1'b0;
  logic t1_on = 1'b0;
  logic peer_rxd;
  logic rxd_wire;
  logic irq;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [7:0] d;
  logic [1:0] m;
  logic b8;
  logic [10:0] f;
  logic [7:0] bits;
  realtime t0;
  int n;
  int seed = 26;
  int miscompares = 0;
  int samples_checked = 0;
  szu_req_s req = '0;
  szu_pin_s pins;
  logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_BUF, ADDR_RELL, ADDR_RELH, ADDR_RSEL, 8'h00};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'hd9, 8'h03, 8'h00, 8'h00};
  logic [7:0] mc [3] = '{8'hf0, 8'hf0, 8'hc0};

  // 200 MHz core clock
  always #2.5 clk = ~clk;
  // Timer overflow every second cycle while enabled
  always @(posedge clk) t1_ovf <= t1_on & ~t1_ovf;
  // Device owns the receive line while its enable is high
  assign rxd_wire = pins.rxd_oe ? pins.rxd_out : peer_rxd;

  szu_uart u_szu_uart (.CLK_SYS(clk), .RST(rst), .BUS_REQ(req), .BUS_RDATA(rdata),
    .T1_OVF(t1_ovf), .RXD_IN(rxd_wire), .PINS(pins), .IRQ(irq));
  szu_peer u_szu_peer (.clk(clk), .txd(pins.txd), .rxd(peer_rxd));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= w;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : rd

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung frame
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wr(8'h00, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      chk(v, re[i]);
    end
    // Fast rates: double on, reload at top
    wr(ADDR_PWR, 8'h80);
    wr(ADDR_RELL, 8'hff);
    for (int k = 0; k < 3; k++) begin
      m = 2'(k + 1);
      n = (k == 0) ? 8 : 9;
      wr(ADDR_RSEL, (k == 0) ? 8'h00 : 8'h80);
      t1_on <= (k == 0);
      d = 8'($random(seed));
      b8 = 1'($random(seed));
      wr(ADDR_CTRL, {m, 2'b00, b8, 3'b000});
      fork
        wr(ADDR_BUF, d);
        u_szu_peer.catch_frame(n, BIT, f);
      join
      chk(f, (k == 0) ? {2'b11, d, 1'b0} : {1'b1, b8, d, 1'b0});
      rd(ADDR_CTRL, v);
      chk(v[1], 1'b1);
      repeat (BIT) @(posedge clk);
      wr(ADDR_CTRL, {m, 6'h10});
      d = ~d;
      b8 = 1'($random(seed));
      u_szu_peer.send({b8, d}, n, BIT);
      rd(ADDR_BUF, v);
      chk(v, d);
      rd(ADDR_CTRL, v);
      chk(v[0], 1'b1);
      if (k > 0) chk(v[2], b8);
    end
    // Multiprocessor filter, then reception off
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, mc[i]);
      u_szu_peer.send({i[0], 8'h5a}, 9, BIT);
      rd(ADDR_CTRL, v);
      chk(v[0], i == 1);
    end
    // Interrupt raise, mask and clear
    wr(ADDR_ICLR, 8'h03);
    wr(ADDR_IEN, 8'h01);
    wr(ADDR_CTRL, 8'hd0);
    u_szu_peer.send(9'h1a5, 9, BIT);
    chk(irq, 1'b1);
    wr(ADDR_IEN, 8'h00);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(ADDR_IST, v);
    chk(v[0], 1'b1);
    wr(ADDR_ICLR, 8'h01);
    wr(ADDR_IEN, 8'h01);
    @(negedge clk);
    chk(irq, 1'b0);
    // Fixed nine-bit rate without doubling: 64 clocks a bit
    wr(ADDR_PWR, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    d = 8'($random(seed));
    fork
      wr(ADDR_BUF, d);
      u_szu_peer.catch_frame(9, 2 * BIT, f);
    join
    chk(f, {2'b10, d, 1'b0});
    repeat (2 * BIT) @(posedge clk);
    // Shift-register transmit
    wr(ADDR_CTRL, 8'h00);
    d = 8'($random(seed));
    fork
      wr(ADDR_BUF, d);
      for (int i = 0; i < 8; i++) begin
        @(posedge pins.txd);
        #1;
        bits[i] = pins.rxd_out;
        chk(pins.rxd_oe, 1'b1);
        if (i == 1) chk((($realtime - t0) / 5.0) > 11.9, 1'b1);
        t0 = $realtime;
      end
    join
    chk(bits, d);
    repeat (20) @(posedge clk);
    rd(ADDR_CTRL, v);
    chk({pins.rxd_oe, v[1]}, 2'b01);
    // Shift-register receive, peer drives data on clock falls
    d = 8'($random(seed));
    fork
      wr(ADDR_CTRL, 8'h10);
      u_szu_peer.shift_in(d);
    join
    repeat (24) @(posedge clk);
    rd(ADDR_BUF, v);
    chk(v, d);
    rd(ADDR_CTRL, v);
    chk({pins.rxd_oe, v[0]}, 2'b01);
    tally_and_finish();
  end
endmodule : szu_uart_bench
